// ---- include/imu_pkg.sv ----
// constants and types of the integer multiply unit
// assumes one core clock domain shared with the instruction decoder
package imu_pkg;
	localparam int DATA_W = 16;
	localparam int PROD_W = 32;
	localparam int ACC_W = 40;
	localparam int LIT_W = 5;
	localparam int IDX_W = 4;
	localparam logic [3:0] FILE_LO_IDX = 4'h2;
	localparam logic [3:0] FILE_HI_IDX = 4'h3;
	localparam logic [3:0] IDX_STEP = 4'h1;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
	localparam logic [3:0] IDX_RST = 4'h0;

	// destination form of a multiply
	typedef enum logic [1:0] {
		imu_form_pair,
		imu_form_word,
		imu_form_acc,
		imu_form_file
	} imu_form_t;

	typedef enum logic {
		imu_st_idle,
		imu_st_extra
	} imu_state_t;
endpackage

// ---- rtl/imu_top.sv ----
// integer multiply datapath: one request in, registered write-back out
// assumes the decoder drives requests synchronously and honours o_busy
`timescale 1ns/1ns
module imu_top (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_valid,
	input wire imu_pkg::imu_form_t i_form,
	input wire logic i_base_signed,
	input wire logic i_src_signed,
	input wire logic i_use_lit,
	input wire logic i_sfr_ext,
	input wire logic [15:0] i_base_operand_reg,
	input wire logic [15:0] i_source_operand_reg,
	input wire logic [4:0] i_short_literal,
	input wire logic [15:0] i_file_operand,
	input wire logic [15:0] i_default_work_reg,
	input wire logic [3:0] i_dst_idx,
	input wire logic i_acc_sel,
	output logic o_busy,
	output logic o_lo_we,
	output logic [3:0] o_lo_idx,
	output logic [15:0] o_lo_data,
	output logic o_hi_we,
	output logic [3:0] o_hi_idx,
	output logic [15:0] o_hi_data,
	output logic o_acc_we,
	output logic o_acc_sel,
	output logic [39:0] o_acc_data,
	output logic o_status_we
);
	// 17-bit extension lets one signed multiplier serve all four signedness variants
	function automatic logic [31:0] mul_ext(input logic [15:0] a, input logic [15:0] b,
		input logic sa, input logic sb);
		logic signed [16:0] ea;
		logic signed [16:0] eb;
		logic signed [33:0] p;
		ea = $signed({sa & a[15], a});
		eb = $signed({sb & b[15], b});
		p = ea * eb;
		return p[31:0];
	endfunction

	imu_pkg::imu_state_t state, next_state;
	imu_pkg::imu_form_t pend_form, next_pend_form;
	logic [15:0] pend_a, next_pend_a, pend_b, next_pend_b;
	logic pend_sa, next_pend_sa, pend_sb, next_pend_sb, pend_acc, next_pend_acc;
	logic [3:0] pend_idx, next_pend_idx;
	logic next_busy, next_lo_we, next_hi_we, next_acc_we, next_acc_sel;
	logic [3:0] next_lo_idx, next_hi_idx;
	logic [15:0] next_lo_data, next_hi_data;
	logic [39:0] next_acc_data;

	logic [15:0] fr_a, fr_b;
	logic fr_sa, fr_sb;
	imu_pkg::imu_form_t cur_form;
	logic [15:0] cur_a, cur_b, cur_lo;
	logic cur_sa, cur_sb, cur_acc, issue;
	logic [3:0] cur_idx;
	logic [31:0] cur_prod;

	always_comb begin
		// operand resolution for a fresh request
		fr_a = i_base_operand_reg;
		fr_b = i_source_operand_reg;
		fr_sa = i_base_signed;
		fr_sb = i_src_signed;
		if (i_form == imu_pkg::imu_form_file) begin
			fr_a = i_file_operand;
			fr_b = i_default_work_reg;
			fr_sa = 1'b0;
			fr_sb = 1'b0;
		end else if (i_use_lit) begin
			fr_b = {11'h000, i_short_literal};
			fr_sb = 1'b0;
		end
	end

	always_comb begin
		if (state == imu_pkg::imu_st_extra) begin
			cur_form = pend_form;
			cur_a = pend_a;
			cur_b = pend_b;
			cur_sa = pend_sa;
			cur_sb = pend_sb;
			cur_idx = pend_idx;
			cur_acc = pend_acc;
		end else begin
			cur_form = i_form;
			cur_a = fr_a;
			cur_b = fr_b;
			cur_sa = fr_sa;
			cur_sb = fr_sb;
			cur_idx = i_dst_idx;
			cur_acc = i_acc_sel;
		end
		cur_prod = mul_ext(cur_a, cur_b, cur_sa, cur_sb);
		cur_lo = cur_prod[15:0];
		issue = (state == imu_pkg::imu_st_extra) ||
			(state == imu_pkg::imu_st_idle && i_valid && !i_sfr_ext);
	end

	always_comb begin
		next_state = state;
		next_pend_form = pend_form;
		next_pend_a = pend_a;
		next_pend_b = pend_b;
		next_pend_sa = pend_sa;
		next_pend_sb = pend_sb;
		next_pend_idx = pend_idx;
		next_pend_acc = pend_acc;
		next_busy = 1'b0;
		next_lo_we = 1'b0;
		next_hi_we = 1'b0;
		next_acc_we = 1'b0;
		next_lo_idx = o_lo_idx;
		next_hi_idx = o_hi_idx;
		next_lo_data = o_lo_data;
		next_hi_data = o_hi_data;
		next_acc_sel = o_acc_sel;
		next_acc_data = o_acc_data;
		case (state)
			imu_pkg::imu_st_idle: begin
				if (i_valid && i_sfr_ext) begin
					// hold the request one cycle for the slow peripheral access
					next_state = imu_pkg::imu_st_extra;
					next_busy = 1'b1;
					next_pend_form = i_form;
					next_pend_a = fr_a;
					next_pend_b = fr_b;
					next_pend_sa = fr_sa;
					next_pend_sb = fr_sb;
					next_pend_idx = i_dst_idx;
					next_pend_acc = i_acc_sel;
				end
			end
			imu_pkg::imu_st_extra: begin
				next_state = imu_pkg::imu_st_idle;
			end
			default: begin
				next_state = imu_pkg::imu_st_idle;
			end
		endcase
		if (issue) begin
			case (cur_form)
				imu_pkg::imu_form_pair: begin
					next_lo_we = 1'b1;
					next_hi_we = 1'b1;
					next_lo_idx = cur_idx;
					// index wraps at the top of the register file
					next_hi_idx = cur_idx + imu_pkg::IDX_STEP;
					next_lo_data = cur_prod[15:0];
					next_hi_data = cur_prod[31:16];
				end
				imu_pkg::imu_form_word: begin
					next_lo_we = 1'b1;
					next_lo_idx = cur_idx;
					next_lo_data = cur_lo;
				end
				imu_pkg::imu_form_acc: begin
					next_acc_we = 1'b1;
					next_acc_sel = cur_acc;
					next_acc_data = {{8{cur_prod[31] & (cur_sa | cur_sb)}}, cur_prod};
				end
				imu_pkg::imu_form_file: begin
					next_lo_we = 1'b1;
					next_hi_we = 1'b1;
					next_lo_idx = imu_pkg::FILE_LO_IDX;
					next_hi_idx = imu_pkg::FILE_HI_IDX;
					next_lo_data = cur_prod[15:0];
					next_hi_data = cur_prod[31:16];
				end
				default: begin
					next_lo_we = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= imu_pkg::imu_st_idle;
			pend_form <= imu_pkg::imu_form_pair;
			pend_a <= imu_pkg::DATA_RST;
			pend_b <= imu_pkg::DATA_RST;
			pend_sa <= 1'b0;
			pend_sb <= 1'b0;
			pend_idx <= imu_pkg::IDX_RST;
			pend_acc <= 1'b0;
			o_busy <= 1'b0;
			o_lo_we <= 1'b0;
			o_hi_we <= 1'b0;
			o_acc_we <= 1'b0;
			o_lo_idx <= imu_pkg::IDX_RST;
			o_hi_idx <= imu_pkg::IDX_RST;
			o_lo_data <= imu_pkg::DATA_RST;
			o_hi_data <= imu_pkg::DATA_RST;
			o_acc_sel <= 1'b0;
			o_acc_data <= imu_pkg::ACC_RST;
			o_status_we <= 1'b0;
		end else begin
			state <= next_state;
			pend_form <= next_pend_form;
			pend_a <= next_pend_a;
			pend_b <= next_pend_b;
			pend_sa <= next_pend_sa;
			pend_sb <= next_pend_sb;
			pend_idx <= next_pend_idx;
			pend_acc <= next_pend_acc;
			o_busy <= next_busy;
			o_lo_we <= next_lo_we;
			o_hi_we <= next_hi_we;
			o_acc_we <= next_acc_we;
			o_lo_idx <= next_lo_idx;
			o_hi_idx <= next_hi_idx;
			o_lo_data <= next_lo_data;
			o_hi_data <= next_hi_data;
			o_acc_sel <= next_acc_sel;
			o_acc_data <= next_acc_data;
			o_status_we <= 1'b0;
		end
	end

	// checks
	logic fresh;
	logic [31:0] lit_expect;
	assign fresh = state == imu_pkg::imu_st_idle && i_valid && !i_sfr_ext;
	assign lit_expect = mul_ext(i_base_operand_reg, {11'h000, i_short_literal},
		i_base_signed, 1'b0);

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_sfr_req;
		state == imu_pkg::imu_st_idle && i_valid && i_sfr_ext;
	endsequence
	sequence s_held;
		o_busy && !o_lo_we && !o_hi_we && !o_acc_we;
	endsequence

	a_pair_write: assert property (
		issue && cur_form == imu_pkg::imu_form_pair |=> o_lo_we && o_hi_we &&
		{o_hi_data, o_lo_data} == $past(cur_prod) &&
		o_hi_idx == 4'($past(cur_idx) + imu_pkg::IDX_STEP))
		else $error("pair product write wrong");
	a_word_write: assert property (
		issue && cur_form == imu_pkg::imu_form_word |=> o_lo_we && !o_hi_we &&
		!o_acc_we && o_lo_data == $past(cur_lo) && o_lo_idx == $past(cur_idx))
		else $error("word product write wrong");
	a_acc_write: assert property (
		issue && cur_form == imu_pkg::imu_form_acc |=> o_acc_we && !o_lo_we &&
		!o_hi_we && o_acc_data[31:0] == $past(cur_prod) && o_acc_sel == $past(cur_acc))
		else $error("accumulator write wrong");
	a_lit_pair: assert property (
		fresh && i_use_lit && i_form == imu_pkg::imu_form_pair |=>
		{o_hi_data, o_lo_data} == $past(lit_expect))
		else $error("literal pair product wrong");
	a_lit_word: assert property (
		fresh && i_use_lit && i_form == imu_pkg::imu_form_word |=>
		o_lo_we && o_lo_data == $past(lit_expect[15:0]))
		else $error("literal word product wrong");
	a_sfr_extra: assert property (
		s_sfr_req |=> s_held ##1 (!o_busy && (o_lo_we || o_hi_we || o_acc_we)))
		else $error("extra cycle not taken");
	a_flags_kept: assert property (
		$rose(o_lo_we) || $rose(o_acc_we) |-> !o_status_we)
		else $error("status flags touched");
	a_file_regs: assert property (
		fresh && i_form == imu_pkg::imu_form_file |=> o_lo_we && o_hi_we &&
		o_lo_idx == imu_pkg::FILE_LO_IDX && o_hi_idx == imu_pkg::FILE_HI_IDX &&
		{o_hi_data, o_lo_data} == $past(i_file_operand) * $past(i_default_work_reg))
		else $error("file form write wrong");
	// a held request must use the operands seen at the take edge, not the later pins
	a_file_late: assert property (
		s_sfr_req ##0 (i_form == imu_pkg::imu_form_file) |=> ##1 (o_lo_we && o_hi_we &&
		o_lo_idx == imu_pkg::FILE_LO_IDX && o_hi_idx == imu_pkg::FILE_HI_IDX &&
		{o_hi_data, o_lo_data} == $past(i_file_operand, 2) * $past(i_default_work_reg, 2)))
		else $error("held file form write wrong");
endmodule

// ---- tb/integer_multiply_unit_test.sv ----
// self-checking bench of the integer multiply unit, one scenario task per behaviour
// assumes imu_pkg is compiled first; the assertions sit in the design itself
`timescale 1ns/1ns
module integer_multiply_unit_test;
	localparam imu_pkg::imu_form_t fp = imu_pkg::imu_form_pair;
	localparam imu_pkg::imu_form_t fw = imu_pkg::imu_form_word;
	localparam imu_pkg::imu_form_t fa = imu_pkg::imu_form_acc;
	localparam imu_pkg::imu_form_t ff = imu_pkg::imu_form_file;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, bs = 1'b0, ss = 1'b0, ul = 1'b0;
	logic sfr = 1'b0, as = 1'b0;
	imu_pkg::imu_form_t form = fp;
	logic [15:0] ra = 16'h0000, rb = 16'h0000, fo = 16'h0000, wr = 16'h0000;
	logic [4:0] lit = 5'h00;
	logic [3:0] idx = 4'h0;
	logic busy, lwe, hwe, awe, asel, swe;
	logic [3:0] lidx, hidx;
	logic [15:0] ld, hd;
	logic [39:0] ad;
	int n_errors = 0;
	int n_compared = 0;
	imu_top DUT (.i_clk_sys(clk), .i_sys_rst(rst), .i_valid(vld), .i_form(form),
		.i_base_signed(bs), .i_src_signed(ss), .i_use_lit(ul), .i_sfr_ext(sfr),
		.i_base_operand_reg(ra), .i_source_operand_reg(rb), .i_short_literal(lit),
		.i_file_operand(fo), .i_default_work_reg(wr), .i_dst_idx(idx), .i_acc_sel(as),
		.o_busy(busy), .o_lo_we(lwe), .o_lo_idx(lidx), .o_lo_data(ld), .o_hi_we(hwe),
		.o_hi_idx(hidx), .o_hi_data(hd), .o_acc_we(awe), .o_acc_sel(asel),
		.o_acc_data(ad), .o_status_we(swe));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// one instruction; operands are scrambled after the take edge to catch late sampling
	task automatic run(input imu_pkg::imu_form_t f, input logic b_s, input logic s_s,
		input logic u_l, input logic x_t, input logic [15:0] a, input logic [15:0] b,
		input logic [4:0] l, input logic [3:0] d, input logic c);
		logic signed [16:0] x, y;
		logic signed [33:0] p;
		logic fl, pr, wd, ac, sg;
		fl = f == ff;
		pr = fl || f == fp;
		wd = f == fw;
		ac = f == fa;
		x = {b_s & a[15] & !fl, a};
		y = u_l ? {12'h000, l} : {s_s & b[15] & !fl, b};
		p = x * y;
		sg = !fl && (b_s || (s_s && !u_l)) && p[31];
		@(negedge clk);
		vld = 1'b1; form = f; bs = b_s; ss = s_s; ul = u_l; sfr = x_t;
		ra = fl ? ~a : a; rb = fl ? ~b : b; fo = a; wr = b; lit = l; idx = d; as = c;
		@(negedge clk);
		vld = 1'b0; ra = ~ra; rb = ~rb; fo = ~fo; wr = ~wr; lit = ~lit;
		if (x_t) begin
			chk(busy, 1'b1, "busy");
			chk(lwe | hwe | awe, 1'b0, "early write");
			@(negedge clk);
		end
		chk(busy, 1'b0, "busy end");
		chk(swe, 1'b0, "flag write");
		chk(lwe, pr | wd, "low we");
		chk(hwe, pr, "high we");
		chk(awe, ac, "acc we");
		if (pr | wd) chk({lidx, ld}, {fl ? 4'h2 : d, p[15:0]}, "low");
		if (pr) chk({hidx, hd}, {fl ? 4'h3 : d + 4'h1, p[31:16]}, "high");
		if (ac) chk(asel, c, "acc sel");
		if (ac) chk(ad, {{8{sg}}, p[31:0]}, "acc data");
	endtask
	task automatic t_pair();
		for (int i = 0; i < 4; i++) begin
			run(fp, i[1], i[0], 1'b0, 1'b0, 16'h8001, 16'hfffe, 5'h00, i[0] ? 4'h5 : 4'hf, 1'b0);
		end
		$display("pair test done");
	endtask
	task automatic t_word();
		for (int i = 0; i < 4; i++) begin
			run(fw, i[0], i[1], 1'b0, 1'b0, 16'h8003, 16'h7ffd, 5'h00, 4'h8, 1'b0);
		end
		$display("word test done");
	endtask
	task automatic t_acc();
		for (int i = 0; i < 4; i++) begin
			run(fa, i[1], i[0], 1'b0, 1'b0, 16'hff00, 16'h0300, 5'h00, 4'h0, i[0]);
		end
		run(fa, 1'b0, 1'b0, 1'b0, 1'b0, 16'hffff, 16'hffff, 5'h00, 4'h0, 1'b1);
		$display("acc test done");
	endtask
	task automatic t_lit();
		for (int i = 0; i < 2; i++) begin
			run(fp, i[0], 1'b1, 1'b1, 1'b0, 16'h8000, 16'h1234, 5'h1f, 4'h7, 1'b0);
			run(fw, i[0], 1'b1, 1'b1, 1'b0, 16'hc001, 16'h1234, 5'h13, 4'h1, 1'b0);
			run(fa, i[0], 1'b1, 1'b1, 1'b0, 16'h8000, 16'h1234, 5'h1f, 4'h0, i[0]);
		end
		$display("literal test done");
	endtask
	task automatic t_sfr();
		run(fp, 1'b1, 1'b1, 1'b0, 1'b1, 16'h1234, 16'h8678, 5'h00, 4'h3, 1'b0);
		run(fw, 1'b0, 1'b1, 1'b0, 1'b1, 16'hf234, 16'h8678, 5'h00, 4'h4, 1'b0);
		run(ff, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0102, 16'h0304, 5'h00, 4'h0, 1'b0);
		$display("extra cycle test done");
	endtask
	task automatic t_file();
		run(ff, 1'b1, 1'b1, 1'b0, 1'b0, 16'hffff, 16'h8000, 5'h00, 4'h9, 1'b0);
		run(ff, 1'b0, 1'b0, 1'b0, 1'b0, 16'h00ff, 16'hfff0, 5'h00, 4'hc, 1'b0);
		$display("file test done");
	endtask
	initial begin
		repeat (6) @(negedge clk);
		chk(lwe | hwe | awe | busy, 1'b0, "reset");
		rst = 1'b0;
		t_pair();
		t_word();
		t_acc();
		t_lit();
		t_sfr();
		t_file();
		end_sim();
	end
	// the tests need about 57 cycles; four thousand ns leaves ample margin
	initial begin
		#4000;
		n_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_sim();
	end
endmodule
